//--- inc/mii_port_pkg.sv
// Shared constants and types for the quad MII port block
package mii_port_pkg;

	// ------------------------------------------------------------
	// Clocking
	// ------------------------------------------------------------
	localparam int MCLK_HZ = 200_000_000;
	localparam int F100_HZ = 25_000_000;
	localparam int F10N_HZ = 2_500_000;
	localparam int F10S_HZ = 10_000_000;
	localparam int DIV_W = 6;
	localparam logic [DIV_W-1:0] HALF_100 = DIV_W'(MCLK_HZ / (2 * F100_HZ));
	localparam logic [DIV_W-1:0] HALF_10N = DIV_W'(MCLK_HZ / (2 * F10N_HZ));
	localparam logic [DIV_W-1:0] HALF_10S = DIV_W'(MCLK_HZ / (2 * F10S_HZ));

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_BASE = 8'h00;
	localparam logic [ADDR_W-1:0] STAT_BASE = 8'h10;
	localparam int CTRL_SPEED100 = 0;
	localparam int CTRL_SERIAL = 1;
	localparam int CTRL_FDX = 2;
	localparam int CTRL_CRS_RX_ONLY = 3;
	localparam int CTRL_BYPASS = 4;
	localparam int CTRL_PKT_CODE_EN = 8;
	localparam int CTRL_LINK_CODE_EN = 9;
	localparam logic [9:0] CTRL_RESET = 10'h001;
	localparam int STAT_CRS = 0;
	localparam int STAT_COL = 1;
	localparam int STAT_RX_DV = 2;
	localparam int STAT_TX_EN = 3;
	localparam int STAT_JABBER = 4;
	localparam int STAT_ENABLED = 5;

	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	localparam logic [3:0] CODE_PKT = 4'h2;
	localparam logic [3:0] CODE_LINK = 4'h3;
	localparam logic [3:0] CODE_PREM = 4'h4;
	localparam logic [3:0] CODE_CODE = 4'h5;
	localparam logic [4:0] SYM_TX_ERR = 5'h04;

	typedef enum logic [1:0] {ERR_PKT = 2'h0, ERR_LINK = 2'h1, ERR_PREM = 2'h2, ERR_CODE = 2'h3} err_kind_t;
	typedef enum logic [2:0] {CM_100 = 3'h1, CM_10N = 3'h2, CM_10S = 3'h4} clk_mode_t;

	typedef struct packed {
		logic en;
		logic er;
		logic [3:0] d;
	} mii_tx_t;

	typedef struct packed {
		logic active;
		logic valid;
		logic err;
		err_kind_t kind;
		logic jabber;
		logic [4:0] sym;
	} rx_media_t;

	typedef struct packed {
		logic valid;
		logic [4:0] sym;
	} tx_media_t;

endpackage : mii_port_pkg

//--- hdl/mii_quad_port.sv
// Four-channel MII port logic in normal (non-bused) mode
//
// What this block does
// R01: Half-duplex collision is async AND, tx_en, rx activity
// R02: Serial 10Base-T: collision shows jabber expiry
// R03: Carrier sense on tx or rx nonidle
// R04: Carrier sense held throughout collision
// R05: Rx-only select: carrier sense on receive only
// R06: Rx-only select from register or strap pin
// R07: Rx clock 25, 2.5 or 10 MHz
// R08: Rx nibble, valid, error synchronous to rx clock
// R09: Packet/link codes only when both enables set
// R10: Premature end 4h, code error 5h
// R11: Serial 10M: data on bit 0, rest floated
// R12: Rx data valid while decoding; unused serially
// R13: Rx error on coding error in frame
// R14: Bypass at 100M: rx error is fifth bit
// R15: Tx clock 25, 2.5 or 10 MHz
// R16: Tx inputs sampled on tx clock rising edge
// R17: Controller holds tx_en exactly with valid data
// R18: Serial 10M: only tx bit 0, enable marks
// R19: Tx error sends symbol 00100
// R20: Bypass: tx error is fifth bit; serial ignores
// R21: Port enable input tied high when used
// R22: Bit 29.8 means register 29 bit 8
// R23: Four independent port copies
`timescale 1ns/1ps

module mii_quad_port #(
	parameter int CHANNELS = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [mii_port_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [CHANNELS-1:0] mii_enable,
	input wire logic [CHANNELS-1:0] carrier_sense_rx_only_strap,
	input wire mii_port_pkg::mii_tx_t [CHANNELS-1:0] tx_pins,
	input wire mii_port_pkg::rx_media_t [CHANNELS-1:0] rx_media,
	output mii_port_pkg::tx_media_t [CHANNELS-1:0] tx_media,
	output logic [CHANNELS-1:0] tx_clk,
	output logic [CHANNELS-1:0] rx_clk,
	output logic [CHANNELS-1:0][3:0] rxd,
	output logic [CHANNELS-1:0][3:0] rxd_oe,
	output logic [CHANNELS-1:0] rx_dv,
	output logic [CHANNELS-1:0] rx_er,
	output logic [CHANNELS-1:0] col,
	output logic [CHANNELS-1:0] crs
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic mii_port_pkg::clk_mode_t mode_of(input logic speed100, input logic serial);
		if (speed100)
			mode_of = mii_port_pkg::CM_100;
		else if (serial)
			mode_of = mii_port_pkg::CM_10S;
		else
			mode_of = mii_port_pkg::CM_10N;
	endfunction : mode_of

	function automatic logic [mii_port_pkg::DIV_W-1:0] half_of(input mii_port_pkg::clk_mode_t m);
		case (m)
			mii_port_pkg::CM_100: half_of = mii_port_pkg::HALF_100;
			mii_port_pkg::CM_10S: half_of = mii_port_pkg::HALF_10S;
			default: half_of = mii_port_pkg::HALF_10N;
		endcase
	endfunction : half_of

	function automatic logic [4:0] enc4b5b(input logic [3:0] n);
		case (n)
			4'h0: enc4b5b = 5'h1E;
			4'h1: enc4b5b = 5'h09;
			4'h2: enc4b5b = 5'h14;
			4'h3: enc4b5b = 5'h15;
			4'h4: enc4b5b = 5'h0A;
			4'h5: enc4b5b = 5'h0B;
			4'h6: enc4b5b = 5'h0E;
			4'h7: enc4b5b = 5'h0F;
			4'h8: enc4b5b = 5'h12;
			4'h9: enc4b5b = 5'h13;
			4'hA: enc4b5b = 5'h16;
			4'hB: enc4b5b = 5'h17;
			4'hC: enc4b5b = 5'h1A;
			4'hD: enc4b5b = 5'h1B;
			4'hE: enc4b5b = 5'h1C;
			default: enc4b5b = 5'h1D;
		endcase
	endfunction : enc4b5b

	logic [CHANNELS-1:0][9:0] ctrl_reg;
	logic [CHANNELS-1:0][9:0] ctrl_next;
	logic [CHANNELS-1:0][5:0] stat;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	always_comb
	begin
		ctrl_next = ctrl_reg;
		rdata_next = 32'h0000_0000;
		for (int i = 0; i < CHANNELS; i++)
		begin
			if (reg_wr && reg_addr == mii_port_pkg::CTRL_BASE + mii_port_pkg::ADDR_W'(4 * i))
				ctrl_next[i] = reg_wdata[9:0];
			if (reg_rd && reg_addr == mii_port_pkg::CTRL_BASE + mii_port_pkg::ADDR_W'(4 * i))
				rdata_next = {22'h00_0000, ctrl_reg[i]};
			else if (reg_rd && reg_addr == mii_port_pkg::STAT_BASE + mii_port_pkg::ADDR_W'(4 * i))
				rdata_next = {26'h000_0000, stat[i]};
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= {CHANNELS{mii_port_pkg::CTRL_RESET}};
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// ------------------------------------------------------------
	// Per-channel ports
	// ------------------------------------------------------------
	for (genvar ch = 0; ch < CHANNELS; ch++)
	begin : g_port // R23
		logic [7:0] sync1_reg;
		logic [7:0] sync2_reg;
		logic [mii_port_pkg::DIV_W-1:0] div_reg;
		logic [mii_port_pkg::DIV_W-1:0] div_next;
		logic [mii_port_pkg::DIV_W-1:0] half;
		logic clk_reg;
		logic clk_next;
		logic edge_now;
		logic rise;
		logic fall;
		logic port_on;
		logic speed100;
		logic serial10;
		logic bypass;
		logic rx_only;
		logic tx_en_s;
		mii_port_pkg::tx_media_t tx_reg;
		mii_port_pkg::tx_media_t tx_next;
		logic [3:0] rxd_reg;
		logic [3:0] rxd_next;
		logic dv_reg;
		logic dv_next;
		logic er_reg;
		logic er_next;
		logic crs_reg;
		logic crs_next;
		logic col_s;

		// Pins from the controller's domain pass two flops
		always_ff @(posedge mclk)
		begin
			if (!rst_n)
			begin
				sync1_reg <= 8'h00;
				sync2_reg <= 8'h00;
			end
			else
			begin
				sync1_reg <= {mii_enable[ch], carrier_sense_rx_only_strap[ch], tx_pins[ch]};
				sync2_reg <= sync1_reg;
			end
		end

		assign port_on = sync2_reg[7];
		assign tx_en_s = sync2_reg[5];
		assign speed100 = ctrl_reg[ch][mii_port_pkg::CTRL_SPEED100];
		assign serial10 = !speed100 && ctrl_reg[ch][mii_port_pkg::CTRL_SERIAL];
		assign bypass = speed100 && ctrl_reg[ch][mii_port_pkg::CTRL_BYPASS];
		assign rx_only = ctrl_reg[ch][mii_port_pkg::CTRL_CRS_RX_ONLY] || sync2_reg[6]; // R06

		// Clock divider for both MII clocks
		assign half = half_of(mode_of(speed100, ctrl_reg[ch][mii_port_pkg::CTRL_SERIAL]));
		assign edge_now = port_on && div_reg >= half - mii_port_pkg::DIV_W'(1);
		assign rise = edge_now && !clk_reg;
		assign fall = edge_now && clk_reg;

		always_comb
		begin
			div_next = div_reg + mii_port_pkg::DIV_W'(1);
			clk_next = clk_reg;
			if (!port_on)
			begin
				div_next = '0;
				clk_next = 1'b0;
			end
			else if (edge_now)
			begin
				div_next = '0;
				clk_next = !clk_reg; // R07 R15
			end
		end

		always_ff @(posedge mclk)
		begin
			if (!rst_n)
			begin
				div_reg <= '0;
				clk_reg <= 1'b0;
			end
			else
			begin
				div_reg <= div_next;
				clk_reg <= clk_next;
			end
		end

		// Transmit path, sampled at the tx clock rising edge
		always_comb
		begin
			tx_next = tx_reg;
			if (!port_on)
				tx_next = '0;
			else if (rise) // R16
			begin
				tx_next.valid = tx_en_s; // R18
				if (serial10)
					tx_next.sym = {4'h0, sync2_reg[0]}; // R18 R20
				else if (bypass)
					tx_next.sym = {sync2_reg[4], sync2_reg[3:0]}; // R20
				else if (sync2_reg[4])
					tx_next.sym = mii_port_pkg::SYM_TX_ERR; // R19
				else
					tx_next.sym = enc4b5b(sync2_reg[3:0]);
			end
		end

		// Receive path, launched at the rx clock falling edge
		always_comb
		begin
			rxd_next = rxd_reg;
			dv_next = dv_reg;
			er_next = er_reg;
			if (!port_on)
			begin
				rxd_next = 4'h0;
				dv_next = 1'b0;
				er_next = 1'b0;
			end
			else if (fall) // R08
			begin
				rxd_next = rx_media[ch].sym[3:0];
				dv_next = rx_media[ch].valid && !serial10; // R12
				er_next = rx_media[ch].err && !serial10; // R13
				if (serial10)
					rxd_next = {3'h0, rx_media[ch].sym[0]}; // R11
				else if (bypass)
					er_next = rx_media[ch].sym[4]; // R14
				else if (speed100 && rx_media[ch].err)
				begin
					case (rx_media[ch].kind)
						mii_port_pkg::ERR_PREM: rxd_next = mii_port_pkg::CODE_PREM; // R10
						mii_port_pkg::ERR_CODE: rxd_next = mii_port_pkg::CODE_CODE; // R10
						mii_port_pkg::ERR_PKT:
						begin
							if (ctrl_reg[ch][mii_port_pkg::CTRL_PKT_CODE_EN] && ctrl_reg[ch][mii_port_pkg::CTRL_LINK_CODE_EN])
								rxd_next = mii_port_pkg::CODE_PKT; // R09 R22
						end
						default:
						begin
							if (ctrl_reg[ch][mii_port_pkg::CTRL_PKT_CODE_EN] && ctrl_reg[ch][mii_port_pkg::CTRL_LINK_CODE_EN])
								rxd_next = mii_port_pkg::CODE_LINK; // R09 R22
						end
					endcase
				end
			end
		end

		// Carrier sense
		always_comb
		begin
			crs_next = 1'b0;
			if (port_on)
			begin
				if (rx_only)
					crs_next = rx_media[ch].active; // R05
				else
					crs_next = tx_en_s || rx_media[ch].active || col_s; // R03 R04
			end
		end

		always_ff @(posedge mclk)
		begin
			if (!rst_n)
			begin
				tx_reg <= '0;
				rxd_reg <= 4'h0;
				dv_reg <= 1'b0;
				er_reg <= 1'b0;
				crs_reg <= 1'b0;
			end
			else
			begin
				tx_reg <= tx_next;
				rxd_reg <= rxd_next;
				dv_reg <= dv_next;
				er_reg <= er_next;
				crs_reg <= crs_next;
			end
		end

		// Synced collision copy for registered users
		assign col_s = port_on && (serial10 ? rx_media[ch].jabber
			: !ctrl_reg[ch][mii_port_pkg::CTRL_FDX] && tx_en_s && rx_media[ch].active);

		// Collision is a pure gate, not clocked
		always_comb
		begin
			col[ch] = 1'b0;
			if (port_on && serial10)
				col[ch] = rx_media[ch].jabber; // R02
			else if (port_on && !ctrl_reg[ch][mii_port_pkg::CTRL_FDX])
				col[ch] = tx_pins[ch].en && rx_media[ch].active; // R01
		end

		assign tx_media[ch] = tx_reg;
		assign tx_clk[ch] = clk_reg;
		assign rx_clk[ch] = clk_reg;
		assign rxd[ch] = rxd_reg;
		assign rxd_oe[ch] = port_on ? (serial10 ? 4'h1 : 4'hF) : 4'h0; // R11 R21
		assign rx_dv[ch] = dv_reg;
		assign rx_er[ch] = er_reg;
		assign crs[ch] = crs_reg;
		assign stat[ch] = {port_on, rx_media[ch].jabber, tx_en_s, dv_reg, col_s, crs_reg};
	end

endmodule : mii_quad_port

//--- tb/mii_port_checker.sv
// Port-level assertions for the quad MII port
`timescale 1ns/1ps
module mii_port_checker #(
	parameter int CHANNELS = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire mii_port_pkg::mii_tx_t [CHANNELS-1:0] tx_pins,
	input wire mii_port_pkg::rx_media_t [CHANNELS-1:0] rx_media,
	input wire mii_port_pkg::tx_media_t [CHANNELS-1:0] tx_media,
	input wire logic [CHANNELS-1:0] tx_clk,
	input wire logic [CHANNELS-1:0] rx_clk,
	input wire logic [CHANNELS-1:0][3:0] rxd,
	input wire logic [CHANNELS-1:0][3:0] rxd_oe,
	input wire logic [CHANNELS-1:0] rx_dv,
	input wire logic [CHANNELS-1:0] rx_er,
	input wire logic [CHANNELS-1:0] col,
	input wire logic [CHANNELS-1:0] crs
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence rx_busy_seq;
		rx_media[0].active && rxd_oe[0] != 4'h0 ##1 rxd_oe[0] != 4'h0;
	endsequence
	AST_COL: assert property (col[0] |-> (tx_pins[0].en && rx_media[0].active) || rx_media[0].jabber)
		else $error("col without cause");
	AST_CRS_RX: assert property (rx_busy_seq |-> crs[0])
		else $error("crs missed rx");
	AST_CRS_CAUSE: assert property (crs[0] |-> $past(rx_media[0].active) || $past(col[0]) || $past(tx_pins[0].en, 3))
		else $error("crs without cause");
	AST_OE: assert property (rxd_oe[0] inside {4'h0, 4'h1, 4'hF})
		else $error("bad rxd_oe");
	AST_RXD_SYNC: assert property ((!$stable(rxd[0]) || !$stable(rx_dv[0])) && rxd_oe[0] != 4'h0 |-> $fell(rx_clk[0]))
		else $error("rx data off clock");
	AST_TX_SYNC: assert property (!$stable(tx_media[0]) |-> $rose(tx_clk[0]))
		else $error("tx capture off clock");
	AST_DV_SERIAL: assert property ($fell(rx_clk[0]) && rxd_oe[0] == 4'h1 && $past(rxd_oe[0]) == 4'h1 |-> !rx_dv[0] && !rx_er[0])
		else $error("dv in serial");
	AST_CLK_EQ: assert property (tx_clk[0] == rx_clk[0])
		else $error("tx and rx clock differ");
endmodule : mii_port_checker
bind mii_quad_port mii_port_checker #(.CHANNELS(CHANNELS)) u_checker (.mclk(mclk), .rst_n(rst_n), .tx_pins(tx_pins),
	.rx_media(rx_media), .tx_media(tx_media), .tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd), .rxd_oe(rxd_oe),
	.rx_dv(rx_dv), .rx_er(rx_er), .col(col), .crs(crs));

//--- tb/mii_mac_model.sv
// Behavioural MAC driving one port's transmit pins
`timescale 1ns/1ps
module mii_mac_model #(
	parameter logic [3:0] LEN = 4'hF
) (
	input wire logic mclk,
	input wire logic tx_clk,
	input wire logic start,
	input wire logic er_mode,
	output mii_port_pkg::mii_tx_t pins
);
	logic clk_d = 1'b0;
	logic [3:0] left = 4'h0;
	mii_port_pkg::mii_tx_t drv = '0;
	assign pins = drv;
	always @(posedge mclk)
	begin
		clk_d <= tx_clk;
		if (start)
			left <= LEN;
		else if (tx_clk && !clk_d)
		begin
			drv.en <= left != 4'h0;
			drv.d <= left != 4'h0 ? left : ~drv.d;
			drv.er <= er_mode && left != 4'h0;
			left <= left - {3'h0, left != 4'h0};
		end
	end
endmodule : mii_mac_model

//--- tb/phy_mii_port_normal_mode_test.sv
// Self-checking bench for the quad MII port
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; $display("MISMATCH %s %h %h", n, e, a); end end
module phy_mii_port_normal_mode_test;
	typedef struct packed {
		logic [9:0] ctrl;
		logic err;
		mii_port_pkg::err_kind_t kind;
		logic [4:0] sym;
		logic [3:0] rxd;
		logic er;
	} row_t;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata, v;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic start = 1'b0;
	logic er_mode = 1'b0;
	logic [3:0] mii_enable = 4'hF;
	logic [3:0] strap = 4'h0;
	logic [3:0] tx_clk, rx_clk, rx_dv, rx_er, col, crs;
	logic [3:0][3:0] rxd, rxd_oe;
	mii_port_pkg::mii_tx_t mac_pins;
	mii_port_pkg::mii_tx_t [3:1] tx_rest = '0;
	mii_port_pkg::rx_media_t [3:0] rx_media = '0;
	mii_port_pkg::tx_media_t [3:0] tx_media;
	logic [19:0] txr[4] = '{{10'h001, 5'h1F, 5'h04}, {10'h011, 5'h10, 5'h10}, {10'h002, 5'h1E, 5'h00},
		{10'h001, 5'h1F, 5'h1D}};
	int n;
	int error_cnt = 0;
	int samples_checked = 0;
	row_t rows[9] = '{
		'{10'h001, 1'b1, mii_port_pkg::ERR_PREM, 5'h0A, 4'h4, 1'b1},
		'{10'h001, 1'b1, mii_port_pkg::ERR_CODE, 5'h0A, 4'h5, 1'b1},
		'{10'h001, 1'b1, mii_port_pkg::ERR_PKT, 5'h0A, 4'hA, 1'b1},
		'{10'h301, 1'b1, mii_port_pkg::ERR_PKT, 5'h0A, 4'h2, 1'b1},
		'{10'h301, 1'b1, mii_port_pkg::ERR_LINK, 5'h0A, 4'h3, 1'b1},
		'{10'h101, 1'b1, mii_port_pkg::ERR_LINK, 5'h0A, 4'hA, 1'b1},
		'{10'h011, 1'b0, mii_port_pkg::ERR_PKT, 5'h1C, 4'hC, 1'b1},
		'{10'h002, 1'b0, mii_port_pkg::ERR_PKT, 5'h0B, 4'h1, 1'b0},
		'{10'h000, 1'b0, mii_port_pkg::ERR_PKT, 5'h0A, 4'hA, 1'b0}};
	mii_quad_port DUT (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mii_enable(mii_enable), .carrier_sense_rx_only_strap(strap),
		.tx_pins({tx_rest, mac_pins}), .rx_media(rx_media), .tx_media(tx_media), .tx_clk(tx_clk), .rx_clk(rx_clk),
		.rxd(rxd), .rxd_oe(rxd_oe), .rx_dv(rx_dv), .rx_er(rx_er), .col(col), .crs(crs));
	mii_mac_model mac (.mclk(mclk), .tx_clk(tx_clk[0]), .start(start), .er_mode(er_mode), .pins(mac_pins));
	initial
	begin
		forever #2.5 mclk = ~mclk;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic wait_lvl(input bit sel, input logic lvl);
		int k;
		k = 0;
		#1;
		while ((sel ? tx_media[0].valid : rx_clk[0]) !== lvl)
		begin
			@(posedge mclk);
			#1 k++;
			if (k > 900)
			begin
				error_cnt++;
				finish_test();
			end
		end
	endtask : wait_lvl
	task automatic frame;
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		wait_lvl(1, 1);
	endtask : frame
	initial
	begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd(8'h00);
		`CHK("ctrl", {22'h0, mii_port_pkg::CTRL_RESET}, v)
		rd(8'h40);
		`CHK("unmapped", 32'h0, v)
		$display("reset test done");
		foreach (rows[i])
		begin
			wr(8'h00, {22'h0, rows[i].ctrl});
			rx_media[0] <= '{1'b1, 1'b1, rows[i].err, rows[i].kind, 1'b0, rows[i].sym};
			repeat (2)
			begin
				wait_lvl(0, 0);
				wait_lvl(0, 1);
			end
			wait_lvl(0, 0);
			`CHK("rxd", rows[i].rxd, rxd[0] & rxd_oe[0])
			`CHK("oe", rows[i].ctrl[1:0] == 2'h2 ? 4'h1 : 4'hF, rxd_oe[0])
			`CHK("rx_er", rows[i].er, rx_er[0])
			`CHK("rx_dv", rows[i].ctrl[1:0] != 2'h2, rx_dv[0])
			wait_lvl(0, 1);
			n = 0;
			while (rx_clk[0] === 1'b1 && n < 99)
			begin
				@(posedge mclk);
				#1 n++;
			end
			`CHK("half", int'(rows[i].ctrl[0] ? mii_port_pkg::HALF_100 : rows[i].ctrl[1] ? mii_port_pkg::HALF_10S : mii_port_pkg::HALF_10N), n)
		end
		$display("rx table done");
		rx_media[0] <= '0;
		for (int i = 0; i < 4; i++)
		begin
			er_mode <= i < 3;
			wr(8'h00, {22'h0, txr[i][19:10]});
			frame();
			`CHK("sym", txr[i][4:0], tx_media[0].sym & txr[i][9:5])
			`CHK("crs_tx", 1'b1, crs[0])
			wait_lvl(1, 0);
		end
		$display("tx test done");
		wr(8'h00, 32'h1);
		frame();
		rx_media[0].active <= 1'b1;
		#1 `CHK("col", 1'b1, col[0])
		repeat (3) @(posedge mclk);
		#1 `CHK("crs_col", 1'b1, crs[0])
		rx_media[0].active <= 1'b0;
		strap[0] <= 1'b1;
		repeat (6) @(posedge mclk);
		#1 `CHK("crs_strap", 1'b0, crs[0])
		strap[0] <= 1'b0;
		wr(8'h00, 32'h9);
		repeat (6) @(posedge mclk);
		#1 `CHK("crs_reg", 1'b0, crs[0])
		wr(8'h00, 32'h5);
		rx_media[0].active <= 1'b1;
		#1 `CHK("col_fdx", 1'b0, col[0])
		wr(8'h00, 32'h2);
		rx_media[0].jabber <= 1'b1;
		#1 `CHK("jabber", 1'b1, col[0])
		mii_enable[3] <= 1'b0;
		tx_rest[1].en <= 1'b1;
		rx_media[1].active <= 1'b1;
		repeat (6) @(posedge mclk);
		#1 `CHK("col12", 4'h2, col & 4'h6)
		`CHK("oe3", 4'h0, rxd_oe[3])
		rd(8'h14);
		`CHK("stat1", 32'h0000_002B, v)
		$display("collision test done");
		finish_test();
	end
endmodule : phy_mii_port_normal_mode_test
